// [verilog/icc_consts.vh]
// Constants for the input capture channel: register offsets, field positions, modes.
// Assumes inclusion by bare name from the channel's design files.
`ifndef ICC_CONSTS_VH
`define ICC_CONSTS_VH

// Register byte addresses.
`define ICC_ADDR_CTRL 8'h00
`define ICC_ADDR_DATA 8'h04
`define ICC_ADDR_IRQ_STAT 8'h08
`define ICC_ADDR_IRQ_EN 8'h0C
`define ICC_ADDR_IRQ_CLR 8'h10

// Control register field positions.
`define ICC_BIT_ON 15
`define ICC_BIT_STOP_IDLE 13
`define ICC_BIT_FIRST_EDGE 9
`define ICC_BIT_WIDE 8
`define ICC_BIT_TSEL 7
`define ICC_EPI_HI 6
`define ICC_EPI_LO 5
`define ICC_BIT_OVF 4
`define ICC_BIT_BNE 3
`define ICC_MODE_HI 2
`define ICC_MODE_LO 0

// Writable bits of the control register and its reset value.
`define ICC_CTRL_WMASK 32'h0000A3E7
`define ICC_CTRL_RESET 32'h00000000

// Capture trigger modes.
`define ICC_MODE_OFF 3'h0
`define ICC_MODE_EVERY 3'h1
`define ICC_MODE_FALL 3'h2
`define ICC_MODE_RISE 3'h3
`define ICC_MODE_RISE4 3'h4
`define ICC_MODE_RISE16 3'h5
`define ICC_MODE_FIRST 3'h6
`define ICC_MODE_RSVD 3'h7

// Prescaler terminal counts.
`define ICC_PRE4_LAST 4'h3
`define ICC_PRE16_LAST 4'hF

// Interrupt status bit positions.
`define ICC_IRQ_CAPTURE 0
`define ICC_IRQ_OVERFLOW 1

`endif

// [verilog/icc_fifo.v]
// Small capture buffer held in flip-flops, read in arrival order.
// Assumes one clock and a synchronous active-high flush; a push to a full buffer is dropped, even with a pop.
`timescale 1ns/1ps
module icc_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and flush
  input wire core_clk,
  input wire flush,
  // Write side
  input wire push,
  input wire [WIDTH-1:0] push_data,
  output wire full,
  // Read side
  input wire pop,
  output wire [WIDTH-1:0] head_data,
  output wire empty
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire do_push;
  wire do_pop;

  // A push into a full buffer is dropped here, so the caller can flag overflow.
  assign full = (count_reg == DEPTH[AW:0]);
  assign empty = (count_reg == {(AW+1){1'b0}});
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign head_data = mem_reg[rd_ptr_reg];

  // Pointer and occupancy update.
  always @(posedge core_clk) begin
    if (flush) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        mem_reg[wr_ptr_reg] <= push_data;
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// [verilog/icc_channel.v]
// Input capture channel: control register, edge detection, capture buffer and interrupt.
// Assumes timer values and capture pin are synchronous to core_clk, and a plain register port.
// The register port never stalls: writes land at the strobe edge, reads answer a cycle later.
// Clearing the enable bit flushes the buffer one edge after the write, so a read in the very
// next cycle may still report buffered status; software leaves that cycle alone.
//
// Behaviour
// - Enable bit off resets and stops channel.
// - Stop-in-idle halts channel during idle mode.
// - First-edge bit picks first edge, mode 110.
// - Width bit selects 32-bit pair or 16-bit.
// - Timer bit picks source, ignored when wide.
// - Interrupt after one to four capture events.
// - Read-only overflow flag set on capture overflow.
// - Read-only not-empty bit shows buffered captures.
// - Unimplemented control bits always read zero.
// - Four-entry buffer read in arrival order.
// - Six capture trigger modes in mode field.
`timescale 1ns/1ps
`include "icc_consts.vh"
module icc_channel #(
  parameter DEPTH = 4,
  parameter TW = 16
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Timer bases and device state
  input wire [TW-1:0] timer_a_value,
  input wire [TW-1:0] timer_b_value,
  input wire idle_mode,
  // Capture input and interrupt
  input wire capture_input_pin,
  output wire irq
);

  // Registers; all clear on reset, and the channel state also clears while disabled.
  reg [31:0] ctrl_reg;
  reg ovf_reg;
  reg pin_prev_reg;
  reg first_done_reg;
  reg [3:0] pre_cnt_reg;
  reg [1:0] evt_cnt_reg;
  reg [1:0] irq_stat_reg;
  reg [1:0] irq_en_reg;
  // Combinational trigger, decode and datapath signals.
  reg [31:0] cap_value;
  reg capture;
  wire module_on;
  wire running;
  wire rise;
  wire fall;
  wire [2:0] mode;
  wire [1:0] events_per_interrupt;
  wire fifo_full;
  wire fifo_empty;
  wire [31:0] fifo_head;
  wire fifo_pop;
  wire overflow_evt;
  wire irq_evt;
  wire [31:0] ctrl_view;
  wire prescaled;
  wire wr_ctrl;
  wire wr_irq_en;
  wire wr_irq_clr;
  wire rd_data;
  wire [1:0] irq_clr;

  // Pointer width for the buffer depth, so a different power-of-two depth keeps its pointers consistent.
  function integer addr_bits;
    input integer depth;
    integer n;
    begin
      addr_bits = 1;
      for (n = 2; n < depth; n = n * 2) begin
        addr_bits = addr_bits + 1;
      end
    end
  endfunction
  localparam FIFO_AW = addr_bits(DEPTH);

  // Address decode for one strobe; every register matches the same way.
  function reg_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
      reg_hit = strobe && (addr == target);
    end
  endfunction

  // Pick the timer value to capture from the width and timer selects.
  // Narrow captures are zero-extended so the top half never shows stale bits.
  function [31:0] sel_value;
    input wide;
    input tsel;
    input [TW-1:0] ta;
    input [TW-1:0] tb;
    begin
      if (wide) begin
        sel_value = {tb, ta};
      end else if (tsel) begin
        sel_value = {{(32-TW){1'b0}}, ta};
      end else begin
        sel_value = {{(32-TW){1'b0}}, tb};
      end
    end
  endfunction

  // Idle only halts the channel when stop-in-idle is set; otherwise it runs on.
  assign module_on = ctrl_reg[`ICC_BIT_ON];
  assign running = module_on && !(ctrl_reg[`ICC_BIT_STOP_IDLE] && idle_mode);
  assign mode = ctrl_reg[`ICC_MODE_HI:`ICC_MODE_LO];
  assign events_per_interrupt = ctrl_reg[`ICC_EPI_HI:`ICC_EPI_LO];
  assign rise = capture_input_pin && !pin_prev_reg;
  assign fall = !capture_input_pin && pin_prev_reg;
  assign prescaled = (mode == `ICC_MODE_RISE4) || (mode == `ICC_MODE_RISE16);

  // Register strobes decoded once; a write to an unmapped address falls through unused.
  assign wr_ctrl = reg_hit(reg_wr, reg_addr, `ICC_ADDR_CTRL);
  assign wr_irq_en = reg_hit(reg_wr, reg_addr, `ICC_ADDR_IRQ_EN);
  assign wr_irq_clr = reg_hit(reg_wr, reg_addr, `ICC_ADDR_IRQ_CLR);
  assign rd_data = reg_hit(reg_rd, reg_addr, `ICC_ADDR_DATA);
  assign irq_clr = wr_irq_clr ? reg_wdata[1:0] : 2'b00;

  // Trigger decode; the prescaled modes count rising edges before firing.
  // Captures are forced off while halted, so no capture-side state moves; data reads still pop the buffer while enabled.
  always @* begin
    capture = 1'b0;
    case (mode)
      `ICC_MODE_EVERY: capture = rise || fall;
      `ICC_MODE_FALL: capture = fall;
      `ICC_MODE_RISE: capture = rise;
      `ICC_MODE_RISE4: capture = rise && (pre_cnt_reg == `ICC_PRE4_LAST);
      `ICC_MODE_RISE16: capture = rise && (pre_cnt_reg == `ICC_PRE16_LAST);
      `ICC_MODE_FIRST: begin
        // Until the chosen first edge arrives, the opposite edge is ignored.
        if (first_done_reg) begin
          capture = rise || fall;
        end else if (ctrl_reg[`ICC_BIT_FIRST_EDGE]) begin
          capture = rise;
        end else begin
          capture = fall;
        end
      end
      default: capture = 1'b0;
    endcase
    if (!running) begin
      capture = 1'b0;
    end
  end

  // Captured value is taken from the selected timer in the cycle of the edge.
  always @* begin
    cap_value = sel_value(ctrl_reg[`ICC_BIT_WIDE], ctrl_reg[`ICC_BIT_TSEL],
      timer_a_value, timer_b_value);
  end

  assign overflow_evt = capture && fifo_full;
  assign irq_evt = capture && !fifo_full && (evt_cnt_reg == events_per_interrupt);
  assign fifo_pop = rd_data && module_on;

  // The buffer is flushed whenever the enable bit is off, which is the module reset.
  // Depth and pointer width stay tied, so a deeper power-of-two buffer needs only DEPTH changed.
  icc_fifo #(
    .WIDTH(32),
    .DEPTH(DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .flush(rst || !module_on),
    .push(capture),
    .push_data(cap_value),
    .full(fifo_full),
    .pop(fifo_pop),
    .head_data(fifo_head),
    .empty(fifo_empty)
  );

  // Control register with live status fields; unimplemented bits are masked to zero.
  assign ctrl_view = (ctrl_reg & `ICC_CTRL_WMASK)
    | ({31'h0, ovf_reg} << `ICC_BIT_OVF)
    | ({31'h0, !fifo_empty} << `ICC_BIT_BNE);

  // Control register writes; only writable bits are stored.
  // Dropping status and reserved bits here means a read-modify-write cannot set them.
  always @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg <= `ICC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= reg_wdata & `ICC_CTRL_WMASK;
    end
  end

  // Edge history. It clears while disabled, so a re-enable compares the pin against low;
  // a pin that is already high at enable therefore counts as a rising edge.
  always @(posedge core_clk) begin
    if (rst || !module_on) begin
      pin_prev_reg <= 1'b0;
    end else if (running) begin
      pin_prev_reg <= capture_input_pin;
    end
  end

  // Rising-edge prescaler for the divided modes. It is not cleared on a mode change,
  // so software disables the channel before switching between divided modes.
  always @(posedge core_clk) begin
    if (rst || !module_on) begin
      pre_cnt_reg <= 4'h0;
    end else if (running && rise && prescaled) begin
      if (capture) begin
        pre_cnt_reg <= 4'h0;
      end else begin
        pre_cnt_reg <= pre_cnt_reg + 4'h1;
      end
    end
  end

  // First-edge tracking; after the first capture every edge counts.
  always @(posedge core_clk) begin
    if (rst || !module_on) begin
      first_done_reg <= 1'b0;
    end else if (capture) begin
      first_done_reg <= 1'b1;
    end
  end

  // Events since the last interrupt; dropped captures do not count toward the rate.
  always @(posedge core_clk) begin
    if (rst || !module_on) begin
      evt_cnt_reg <= 2'h0;
    end else if (capture && !fifo_full) begin
      if (irq_evt) begin
        evt_cnt_reg <= 2'h0;
      end else begin
        evt_cnt_reg <= evt_cnt_reg + 2'h1;
      end
    end
  end

  // Overflow flag; nothing but a disable clears it, so software sees every loss.
  always @(posedge core_clk) begin
    if (rst || !module_on) begin
      ovf_reg <= 1'b0;
    end else if (overflow_evt) begin
      ovf_reg <= 1'b1;
    end
  end

  // Sticky interrupt status; a set in the same cycle as a clear wins.
  always @(posedge core_clk) begin
    if (rst || !module_on) begin
      irq_stat_reg <= 2'h0;
    end else begin
      irq_stat_reg[`ICC_IRQ_CAPTURE] <= irq_evt ||
        (irq_stat_reg[`ICC_IRQ_CAPTURE] && !irq_clr[`ICC_IRQ_CAPTURE]);
      irq_stat_reg[`ICC_IRQ_OVERFLOW] <= overflow_evt ||
        (irq_stat_reg[`ICC_IRQ_OVERFLOW] && !irq_clr[`ICC_IRQ_OVERFLOW]);
    end
  end

  // Interrupt enable register.
  // Enables survive a disable, so software need not program them again.
  always @(posedge core_clk) begin
    if (rst) begin
      irq_en_reg <= 2'h0;
    end else if (wr_irq_en) begin
      irq_en_reg <= reg_wdata[1:0];
    end
  end

  // Level interrupt, gated by the enable bit so a disabled channel never raises it.
  assign irq = module_on && |(irq_stat_reg & irq_en_reg);

  // Read data one cycle after the strobe; unmapped addresses read zero.
  // A data read pops at its strobe edge, so a read right behind it sees the next entry.
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ICC_ADDR_CTRL: reg_rdata <= ctrl_view;
        `ICC_ADDR_DATA: reg_rdata <= fifo_empty ? 32'h00000000 : fifo_head;
        `ICC_ADDR_IRQ_STAT: reg_rdata <= {30'h0, irq_stat_reg};
        `ICC_ADDR_IRQ_EN: reg_rdata <= {30'h0, irq_en_reg};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

// [dv/icc_pin_src.sv]
// Far-side source of the capture input pin, commanded by the bench.
// Assumes one clock; the pin is a push-pull line that is always driven.
`timescale 1ns/1ps
module icc_pin_src (
  // Clock and request
  input wire core_clk,
  input wire level_req,
  // Pin
  output reg capture_input_pin
);
  // Registered, so every edge lands one whole cycle after the request.
  initial capture_input_pin = 1'b0;
  always @(posedge core_clk) begin
    capture_input_pin <= level_req;
  end
endmodule

// [dv/icc_channel_assertions.sv]
// Port checker for icc_channel: read timing, control bits, interrupt gating.
// Assumes the map of icc_consts.vh; bound onto every icc_channel.
`timescale 1ns/1ps
`include "icc_consts.vh"
module icc_channel_assertions #(
  parameter DEPTH = 4,
  parameter TW = 16
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Channel side
  input wire [TW-1:0] timer_a_value,
  input wire [TW-1:0] timer_b_value,
  input wire idle_mode,
  input wire capture_input_pin,
  input wire irq
);
  reg on_seen_reg;
  // Enable bit as last written; only control writes move it.
  always @(posedge core_clk) begin
    if (rst) begin
      on_seen_reg <= 1'b0;
    end else if (reg_wr && reg_addr == `ICC_ADDR_CTRL) begin
      on_seen_reg <= reg_wdata[`ICC_BIT_ON];
    end
  end
  default clocking @(posedge core_clk); endclocking
  sequence s_cw; reg_wr && reg_addr == `ICC_ADDR_CTRL; endsequence
  sequence s_cr; reg_rd && reg_addr == `ICC_ADDR_CTRL; endsequence
  // Reset clears the outputs even though it is not a disable here.
  property p_rst; rst |=> !irq && reg_rdata == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs live after reset");
  property p_rsvd; disable iff (rst) s_cr |=> reg_rdata[31:16] == 16'h0
    && reg_rdata[14] == 1'b0 && reg_rdata[12:10] == 3'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_keep; disable iff (rst) s_cw ##1 !reg_wr ##1 s_cr |=>
    (reg_rdata & `ICC_CTRL_WMASK) == ($past(reg_wdata, 3) & `ICC_CTRL_WMASK); endproperty
  a_keep: assert property (p_keep) else $error("control field lost");
  property p_offst; disable iff (rst) reg_rd && reg_addr == `ICC_ADDR_CTRL && !on_seen_reg
    |=> reg_rdata[4:3] == 2'b00; endproperty
  a_offst: assert property (p_offst) else $error("status while off");
  property p_idle; disable iff (rst) !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside slot");
  property p_unmap; disable iff (rst) reg_rd && reg_addr > 8'h10 |=> reg_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_offirq; disable iff (rst) !on_seen_reg |-> !irq; endproperty
  a_offirq: assert property (p_offirq) else $error("irq while off");
  property p_mask; disable iff (rst) reg_wr && reg_addr == `ICC_ADDR_IRQ_EN
    && reg_wdata == 32'h0 |=> !irq; endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
endmodule
bind icc_channel icc_channel_assertions #(.DEPTH(DEPTH), .TW(TW)) u_chk (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_a_value(timer_a_value),
  .timer_b_value(timer_b_value), .idle_mode(idle_mode),
  .capture_input_pin(capture_input_pin), .irq(irq));

// [dv/icc_channel_tb_top.sv]
// Bench for icc_channel: trigger mode table, overflow, interrupt rate and mask.
// Assumes the map of icc_consts.vh and the pin source model.
`timescale 1ns/1ps
`include "icc_consts.vh"
module icc_channel_tb_top;
  localparam [7:0] A_CT = `ICC_ADDR_CTRL;
  localparam [7:0] A_DT = `ICC_ADDR_DATA;
  localparam [7:0] A_EN = `ICC_ADDR_IRQ_EN;
  // Scenario table: control bits 15..0, pin pulses, captures expected.
  function [31:0] tab(input integer n);
    begin
      case (n)
        0: tab = 32'h00810102;
        1: tab = 32'h00020101;
        2: tab = 32'h01030101;
        3: tab = 32'h03860102;
        4: tab = 32'h00860101;
        5: tab = 32'h00840401;
        6: tab = 32'h00851001;
        7: tab = 32'h20830100;
        default: tab = 32'h00800100;
      endcase
    end
  endfunction
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [15:0] ta = 16'h1234;
  reg [15:0] tb = 16'h5678;
  reg idle = 1'b0;
  reg pin_req = 1'b0;
  reg [31:0] rv;
  reg [31:0] ev;
  reg [31:0] t;
  wire pin;
  wire irq;
  wire [31:0] reg_rdata;
  integer fails = 0;
  integer check_count = 0;
  integer i;
  integer k;
  icc_pin_src u_pin (.core_clk(core_clk), .level_req(pin_req), .capture_input_pin(pin));
  icc_channel u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_a_value(ta), .timer_b_value(tb), .idle_mode(idle),
    .capture_input_pin(pin), .irq(irq));
  // A 250 MHz clock.
  always #2 core_clk = ~core_clk;
  task chk(input [31:0] seen, input [31:0] e, input [63:0] s);
    begin
      check_count = check_count + 1;
      if (seen !== e) begin
        fails = fails + 1;
        $display("unexpected %0s: expected %h, seen %h", s, e, seen);
      end
    end
  endtask
  // One access then a spare edge, so no strobe is set twice in a step.
  task acc(input w, input [7:0] a, input [31:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
      @(posedge core_clk);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [63:0] s);
    begin
      acc(1'b0, a, 32'h0);
      chk(rv, e, s);
    end
  endtask
  task pulse;
    begin
      pin_req <= 1'b1;
      repeat (4) @(posedge core_clk);
      pin_req <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // Watchdog: the tests need under two thousand cycles.
  initial begin
    repeat (20000) @(posedge core_clk);
    fails = fails + 1;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(A_CT, 32'h0, "ctrl");
    acc(1'b1, A_CT, 32'hFFFFFFFF);
    rd(A_CT, 32'h0000A3E7, "ctrl");
    rd(8'h20, 32'h0, "unmapped");
    // Odd entries run in idle mode; only the stop-in-idle entry must halt.
    for (i = 0; i < 9; i = i + 1) begin
      t = tab(i);
      acc(1'b1, A_CT, 32'h0);
      idle <= i[0];
      acc(1'b1, A_CT, {16'h0, t[31:16]} | 32'h8000);
      for (k = 0; k < t[15:8]; k = k + 1) pulse;
      ev = t[24] ? {tb, ta} : (t[23] ? {16'h0, ta} : {16'h0, tb});
      for (k = 0; k < 3; k = k + 1) begin
        rd(A_DT, (k < t[7:0]) ? ev : 32'h0, "data");
      end
    end
    idle <= 1'b0;
    // Five captures into four entries: the last is dropped.
    acc(1'b1, A_CT, 32'h0);
    acc(1'b1, A_EN, 32'h2);
    acc(1'b1, A_CT, 32'h8083);
    for (k = 1; k < 6; k = k + 1) begin
      ta <= k[15:0];
      pulse;
    end
    #1 chk({31'h0, irq}, 32'h1, "irq");
    rd(A_CT, 32'h809B, "ctrl");
    rd(`ICC_ADDR_IRQ_STAT, 32'h3, "status");
    for (k = 1; k < 6; k = k + 1) rd(A_DT, (k < 5) ? k : 0, "data");
    rd(A_CT, 32'h8093, "ctrl");
    acc(1'b1, `ICC_ADDR_IRQ_CLR, 32'h3);
    #1 chk({31'h0, irq}, 32'h0, "irq");
    acc(1'b1, A_CT, 32'h0);
    rd(A_CT, 32'h0, "ctrl");
    // Interrupt after one to four events, then masked, unmasked and cleared.
    for (i = 0; i < 4; i = i + 1) begin
      acc(1'b1, A_CT, 32'h0);
      acc(1'b1, A_EN, 32'h1);
      acc(1'b1, A_CT, 32'h8003 | (i << 5));
      for (k = 0; k < i; k = k + 1) pulse;
      #1 chk({31'h0, irq}, 32'h0, "irq");
      pulse;
      #1 chk({31'h0, irq}, 32'h1, "irq");
      acc(1'b1, A_EN, 32'h0);
      #1 chk({31'h0, irq}, 32'h0, "irq");
      acc(1'b1, A_EN, 32'h1);
      acc(1'b1, `ICC_ADDR_IRQ_CLR, 32'h1);
      #1 chk({31'h0, irq}, 32'h0, "irq");
    end
    print_verdict;
  end
endmodule
